// file: ssa_stepper_regs.vh
`ifndef SSA_STEPPER_REGS_VH
`define SSA_STEPPER_REGS_VH

// register byte offsets
`define SSA_CTRL_OFS 8'h00
`define SSA_TOTAL_OFS 8'h04
`define SSA_CMD_OFS 8'h08
`define SSA_INDEX_OFS 8'h0C
`define SSA_ACTIVE_OFS 8'h10
`define SSA_STATUS_OFS 8'h14
`define SSA_IRQ_ST_OFS 8'h18
`define SSA_IRQ_MASK_OFS 8'h1C

// control register fields
`define SSA_CTRL_EN_BIT 0
`define SSA_CTRL_ADV_LO 2
`define SSA_CTRL_ADV_HI 3
`define SSA_CTRL_RST_LO 4
`define SSA_CTRL_RST_HI 5
`define SSA_SRC_NONE 2'h0

// command register fields
`define SSA_CMD_STEP_BIT 0
`define SSA_CMD_REWIND_BIT 1
`define SSA_CMD_STORE_BIT 2

// status register fields
`define SSA_ST_WAIT_BIT 0
`define SSA_ST_FRAME_BIT 1
`define SSA_ST_LOAD_BIT 2
`define SSA_ST_SEQ_BIT 3
`define SSA_ST_IDX_LO 8
`define SSA_ST_IDX_HI 13
`define SSA_ST_STEP_P_BIT 14
`define SSA_ST_REWIND_P_BIT 15

// interrupt event bits
`define SSA_EV_N 4
`define SSA_EV_FRAME_START 0
`define SSA_EV_FRAME_END 1
`define SSA_EV_TRIG_IGNORED 2
`define SSA_EV_SET_LOADED 3

// sizes and reset values
`define SSA_PSET_W 32
`define SSA_IDX_W 6
`define SSA_SETS 64
`define SSA_TOTAL_MAX 7'h40
`define SSA_TOTAL_MIN 7'h01
`define SSA_TOTAL_RST 7'h01
`define SSA_CTRL_RST 6'h00
`define SSA_ACTIVE_RST 32'h00000000
`define SSA_MASK_RST 4'h0

`endif

// file: ssa_set_store.v
`timescale 1ns/1ps
`include "ssa_stepper_regs.vh"

module ssa_set_store (
   input wire sys_clk,
   input wire ce,
   input wire wr_en,
   input wire [`SSA_IDX_W-1:0] wr_idx,
   input wire [`SSA_PSET_W-1:0] wr_data,
   input wire [`SSA_IDX_W-1:0] rd_idx,
   output wire [`SSA_PSET_W-1:0] rd_data
);

   reg [`SSA_PSET_W-1:0] mem [0:`SSA_SETS-1];
   reg [`SSA_PSET_W-1:0] rd_data_q;

   // no reset on the array: unstored sets read whatever they hold
   always @(posedge sys_clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_idx] <= wr_data;
         end
         rd_data_q <= mem[rd_idx];
      end
   end

   assign rd_data = rd_data_q;

endmodule

// file: ssa_irq_bank.v
`timescale 1ns/1ps
`include "ssa_stepper_regs.vh"

module ssa_irq_bank (
   input wire sys_clk,
   input wire nrst,
   input wire ce,
   input wire [`SSA_EV_N-1:0] events,
   input wire clr,
   input wire [`SSA_EV_N-1:0] mask,
   output wire [`SSA_EV_N-1:0] status,
   output wire irq
);

   reg [`SSA_EV_N-1:0] status_q;
   reg irq_q;
   wire [`SSA_EV_N-1:0] status_d;

   genvar i;
   generate
      for (i = 0; i < `SSA_EV_N; i = i + 1) begin : g_bit
         // a new event beats the read that clears
         assign status_d[i] = events[i] | (status_q[i] & ~clr);
      end
   endgenerate

   always @(posedge sys_clk) begin
      if (!nrst) begin
         status_q <= {`SSA_EV_N{1'b0}};
         irq_q <= 1'b0;
      end else if (ce) begin
         status_q <= status_d;
         irq_q <= |(status_d & mask);
      end
   end

   assign status = status_q;
   assign irq = irq_q;

endmodule

// file: ssa_stepper.v
// Overview of operation
// - with no line source, step to next set upward only on software step
// - with no line source, restart the cycle only on software rewind
// - stepping past the last configured set wraps back to set zero
// - on sequencer enable, copy stored set zero into the active set
// - set indices run from zero to the configured total minus one
// - each accepted frame trigger latches the active set for that frame
// - a taken step loads the next stored set into the active set
// - a taken rewind loads stored set zero into the active set
// - until a command is taken, every frame keeps the old active set
// - during a set load, leave waiting status and ignore frame triggers
// - disable mid-frame lets the frame finish, then cycling stops
// - on disable, the active set returns to its pre-enable value
// - a frame starts on the rising edge of the trigger input
// - the configured total count of sets is at most sixty-four
// - advance and restart sources each offer none, software only
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssa_stepper_regs.vh"

module ssa_stepper (
   input wire sys_clk,
   input wire nrst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [31:0] reg_rdata,
   input wire frame_trig,
   input wire frame_done,
   output wire acq_start,
   output wire [`SSA_PSET_W-1:0] acq_param,
   output wire trig_wait,
   output wire seq_active,
   output wire irq
);

   localparam [1:0] ST_WAIT = 2'h0;
   localparam [1:0] ST_LOAD_RD = 2'h1;
   localparam [1:0] ST_LOAD_WR = 2'h2;
   localparam [1:0] ST_FRAME = 2'h3;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [5:0] ctrl_q;
   reg [6:0] total_q;
   reg [`SSA_IDX_W-1:0] sel_idx_q;
   reg [`SSA_PSET_W-1:0] active_q;
   reg [`SSA_PSET_W-1:0] active_d;
   reg [`SSA_PSET_W-1:0] backup_q;
   reg [`SSA_PSET_W-1:0] backup_d;
   reg [`SSA_IDX_W-1:0] cur_idx_q;
   reg [`SSA_IDX_W-1:0] cur_idx_d;
   reg [`SSA_IDX_W-1:0] tgt_idx_q;
   reg [`SSA_IDX_W-1:0] tgt_idx_d;
   reg seq_on_q;
   reg seq_on_d;
   reg step_pend_q;
   reg rewind_pend_q;
   reg take_step;
   reg take_rewind;
   reg trig_prev_q;
   reg acq_start_q;
   reg acq_start_d;
   reg [`SSA_PSET_W-1:0] acq_param_q;
   reg trig_wait_q;
   reg [31:0] reg_rdata_q;
   reg [31:0] rdata_d;
   reg [`SSA_EV_N-1:0] mask_q;
   reg [`SSA_EV_N-1:0] ev_d;

   wire [`SSA_EV_N-1:0] irq_status;
   wire [`SSA_PSET_W-1:0] store_rd_data;
   wire ctrl_en;
   wire ctrl_en_d;
   wire adv_sw;
   wire rst_sw;
   wire trig_rise;
   wire wr_ctrl;
   wire wr_total;
   wire wr_cmd;
   wire wr_index;
   wire wr_active;
   wire wr_mask;
   wire rd_irq_st;
   wire cmd_step;
   wire cmd_rewind;
   wire cmd_store;
   wire sw_owns_active;
   wire [6:0] last_w;
   wire [`SSA_IDX_W-1:0] last_idx;
   wire [`SSA_IDX_W-1:0] next_idx;
   wire [6:0] total_wr;

   assign ctrl_en = ctrl_q[`SSA_CTRL_EN_BIT];
   // enable as it will stand next cycle, so waiting drops with the write
   assign ctrl_en_d = wr_ctrl ? reg_wdata[`SSA_CTRL_EN_BIT] : ctrl_en;
   // only the none source is built; a line code blocks software control
   assign adv_sw = ctrl_q[`SSA_CTRL_ADV_HI:`SSA_CTRL_ADV_LO] ==
                   `SSA_SRC_NONE;
   assign rst_sw = ctrl_q[`SSA_CTRL_RST_HI:`SSA_CTRL_RST_LO] ==
                   `SSA_SRC_NONE;

   assign trig_rise = frame_trig & ~trig_prev_q;

   assign wr_ctrl = reg_wr && (reg_addr == `SSA_CTRL_OFS);
   assign wr_total = reg_wr && (reg_addr == `SSA_TOTAL_OFS);
   assign wr_cmd = reg_wr && (reg_addr == `SSA_CMD_OFS);
   assign wr_index = reg_wr && (reg_addr == `SSA_INDEX_OFS);
   assign wr_active = reg_wr && (reg_addr == `SSA_ACTIVE_OFS);
   assign wr_mask = reg_wr && (reg_addr == `SSA_IRQ_MASK_OFS);
   assign rd_irq_st = reg_rd && (reg_addr == `SSA_IRQ_ST_OFS);

   assign cmd_step = wr_cmd && reg_wdata[`SSA_CMD_STEP_BIT];
   assign cmd_rewind = wr_cmd && reg_wdata[`SSA_CMD_REWIND_BIT];
   assign cmd_store = wr_cmd && reg_wdata[`SSA_CMD_STORE_BIT];

   // software edits and stores the active set only while sequencing is off
   assign sw_owns_active = !seq_on_q && !ctrl_en;

   // clamp the total count into one to sixty-four
   assign total_wr = (reg_wdata[31:7] != 25'h0000000) ? `SSA_TOTAL_MAX :
                     (reg_wdata[6:0] > `SSA_TOTAL_MAX) ? `SSA_TOTAL_MAX :
                     (reg_wdata[6:0] < `SSA_TOTAL_MIN) ? `SSA_TOTAL_MIN :
                     reg_wdata[6:0];

   assign last_w = total_q - 7'h01;
   assign last_idx = last_w[`SSA_IDX_W-1:0];
   // total writes are ignored while running, so only the last set lands back on zero
   assign next_idx = (cur_idx_q >= last_idx) ? {`SSA_IDX_W{1'b0}} :
                     cur_idx_q + 6'h01;

   ssa_set_store u_store (
      .sys_clk(sys_clk),
      .ce(ce),
      .wr_en(cmd_store && sw_owns_active),
      .wr_idx(sel_idx_q),
      .wr_data(active_q),
      .rd_idx(tgt_idx_q),
      .rd_data(store_rd_data)
   );

   ssa_irq_bank u_irq (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .events(ev_d),
      .clr(rd_irq_st),
      .mask(mask_q),
      .status(irq_status),
      .irq(irq)
   );

   always @* begin
      state_d = state_q;
      active_d = active_q;
      backup_d = backup_q;
      cur_idx_d = cur_idx_q;
      tgt_idx_d = tgt_idx_q;
      seq_on_d = seq_on_q;
      take_step = 1'b0;
      take_rewind = 1'b0;
      acq_start_d = 1'b0;
      ev_d = {`SSA_EV_N{1'b0}};
      if (wr_active && sw_owns_active) begin
         active_d = reg_wdata;
      end
      case (state_q)
         ST_WAIT: begin
            // enable and disable are decided only here, between frames
            if (ctrl_en && !seq_on_q) begin
               backup_d = active_q;
               seq_on_d = 1'b1;
               tgt_idx_d = {`SSA_IDX_W{1'b0}};
               state_d = ST_LOAD_RD;
            end else if (!ctrl_en && seq_on_q) begin
               active_d = backup_q;
               seq_on_d = 1'b0;
               cur_idx_d = {`SSA_IDX_W{1'b0}};
            end else if (seq_on_q && rewind_pend_q) begin
               take_rewind = 1'b1;
               tgt_idx_d = {`SSA_IDX_W{1'b0}};
               state_d = ST_LOAD_RD;
            end else if (seq_on_q && step_pend_q) begin
               take_step = 1'b1;
               tgt_idx_d = next_idx;
               state_d = ST_LOAD_RD;
            end else if (trig_rise) begin
               acq_start_d = 1'b1;
               ev_d[`SSA_EV_FRAME_START] = 1'b1;
               state_d = ST_FRAME;
            end
         end
         ST_LOAD_RD: begin
            // store read port settles on the target index this cycle
            if (trig_rise) begin
               ev_d[`SSA_EV_TRIG_IGNORED] = 1'b1;
            end
            state_d = ST_LOAD_WR;
         end
         ST_LOAD_WR: begin
            if (trig_rise) begin
               ev_d[`SSA_EV_TRIG_IGNORED] = 1'b1;
            end
            active_d = store_rd_data;
            cur_idx_d = tgt_idx_q;
            ev_d[`SSA_EV_SET_LOADED] = 1'b1;
            state_d = ST_WAIT;
         end
         ST_FRAME: begin
            if (trig_rise) begin
               ev_d[`SSA_EV_TRIG_IGNORED] = 1'b1;
            end
            // disable mid-frame waits here until the frame is sent
            if (frame_done) begin
               ev_d[`SSA_EV_FRAME_END] = 1'b1;
               state_d = ST_WAIT;
            end
         end
         default: begin
            state_d = ST_WAIT;
         end
      endcase
   end

   always @* begin
      rdata_d = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `SSA_CTRL_OFS: rdata_d[5:0] = ctrl_q;
            `SSA_TOTAL_OFS: rdata_d[6:0] = total_q;
            `SSA_INDEX_OFS: rdata_d[`SSA_IDX_W-1:0] = sel_idx_q;
            `SSA_ACTIVE_OFS: rdata_d = active_q;
            `SSA_STATUS_OFS: begin
               rdata_d[`SSA_ST_WAIT_BIT] = trig_wait_q;
               rdata_d[`SSA_ST_FRAME_BIT] = (state_q == ST_FRAME);
               rdata_d[`SSA_ST_LOAD_BIT] = (state_q == ST_LOAD_RD) ||
                                           (state_q == ST_LOAD_WR);
               rdata_d[`SSA_ST_SEQ_BIT] = seq_on_q;
               rdata_d[`SSA_ST_IDX_HI:`SSA_ST_IDX_LO] = cur_idx_q;
               rdata_d[`SSA_ST_STEP_P_BIT] = step_pend_q;
               rdata_d[`SSA_ST_REWIND_P_BIT] = rewind_pend_q;
            end
            `SSA_IRQ_ST_OFS: rdata_d[`SSA_EV_N-1:0] = irq_status;
            `SSA_IRQ_MASK_OFS: rdata_d[`SSA_EV_N-1:0] = mask_q;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (!nrst) begin
         state_q <= ST_WAIT;
         ctrl_q <= `SSA_CTRL_RST;
         total_q <= `SSA_TOTAL_RST;
         sel_idx_q <= {`SSA_IDX_W{1'b0}};
         active_q <= `SSA_ACTIVE_RST;
         backup_q <= `SSA_ACTIVE_RST;
         cur_idx_q <= {`SSA_IDX_W{1'b0}};
         tgt_idx_q <= {`SSA_IDX_W{1'b0}};
         seq_on_q <= 1'b0;
         step_pend_q <= 1'b0;
         rewind_pend_q <= 1'b0;
         trig_prev_q <= 1'b0;
         acq_start_q <= 1'b0;
         acq_param_q <= `SSA_ACTIVE_RST;
         trig_wait_q <= 1'b0;
         reg_rdata_q <= 32'h00000000;
         mask_q <= `SSA_MASK_RST;
      end else if (ce) begin
         state_q <= state_d;
         active_q <= active_d;
         backup_q <= backup_d;
         cur_idx_q <= cur_idx_d;
         tgt_idx_q <= tgt_idx_d;
         seq_on_q <= seq_on_d;
         trig_prev_q <= frame_trig;
         acq_start_q <= acq_start_d;
         reg_rdata_q <= rdata_d;
         if (acq_start_d) begin
            acq_param_q <= active_q;
         end
         // waiting only when idle in wait with nothing about to load
         trig_wait_q <= (state_d == ST_WAIT) && (ctrl_en_d == seq_on_d) &&
                        !(seq_on_d && (rewind_pend_q || step_pend_q ||
                        (cmd_step && adv_sw) ||
                        (cmd_rewind && rst_sw)));
         // a new command beats the take of an older one
         step_pend_q <= seq_on_q && adv_sw &&
                        (cmd_step || (step_pend_q && !take_step &&
                        !take_rewind));
         rewind_pend_q <= seq_on_q && rst_sw &&
                          (cmd_rewind || (rewind_pend_q && !take_rewind));
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata[5:0];
         end
         if (wr_total && sw_owns_active) begin
            total_q <= total_wr;
         end
         if (wr_index) begin
            sel_idx_q <= reg_wdata[`SSA_IDX_W-1:0];
         end
         if (wr_mask) begin
            mask_q <= reg_wdata[`SSA_EV_N-1:0];
         end
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign acq_start = acq_start_q;
   assign acq_param = acq_param_q;
   assign trig_wait = trig_wait_q;
   assign seq_active = seq_on_q;

endmodule

// file: ssa_stepper_properties.sv
`timescale 1ns/1ps
module ssa_stepper_chk (
   input wire sys_clk,
   input wire nrst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire frame_trig,
   input wire frame_done,
   input wire acq_start,
   input wire [31:0] acq_param,
   input wire trig_wait,
   input wire seq_active,
   input wire irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   reg in_frame_q;
   always @(posedge sys_clk) begin
      if (!nrst || frame_done)
         in_frame_q <= 1'b0;
      else if (acq_start)
         in_frame_q <= 1'b1;
   end
   a_start_cause: assert property (
      acq_start |-> $past(trig_wait) && $past(frame_trig)
         && !$past(frame_trig, 2))
      else $error("frame start without trigger rise in wait");
   a_rise_taken: assert property (
      ce && trig_wait && frame_trig && !$past(frame_trig) |=> acq_start)
      else $error("trigger rise in wait not taken");
   a_start_pulse: assert property (acq_start |=> !acq_start)
      else $error("frame start longer than one cycle");
   a_leave_wait: assert property (acq_start |-> !trig_wait)
      else $error("still waiting after frame start");
   a_param_hold: assert property (
      !acq_start |-> $stable(acq_param))
      else $error("frame parameters changed outside frame start");
   a_frame_busy: assert property (
      in_frame_q |-> !trig_wait && !acq_start)
      else $error("wait or start during a frame");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read answer cycle");
   a_enable_load: assert property (
      $rose(seq_active) |-> !trig_wait [*2] ##[1:2] trig_wait)
      else $error("enable load timing wrong");
   c_start: cover property (acq_start);
   c_enable: cover property ($rose(seq_active));
   c_disable: cover property ($fell(seq_active));
endmodule

bind ssa_stepper ssa_stepper_chk i_chk (.sys_clk(sys_clk), .nrst(nrst),
   .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_trig(frame_trig),
   .frame_done(frame_done), .acq_start(acq_start), .acq_param(acq_param),
   .trig_wait(trig_wait), .seq_active(seq_active), .irq(irq));

// file: ssa_frame_src.sv
`timescale 1ns/1ps
module ssa_frame_src (
   input wire sys_clk,
   input wire nrst,
   input wire go,
   input wire rogue,
   input wire [7:0] flen,
   input wire trig_wait,
   input wire acq_start,
   output reg frame_trig,
   output reg frame_done
);
   reg pend_q;
   reg [1:0] hold_q;
   reg [7:0] cnt_q;
   always @(posedge sys_clk) begin
      frame_done <= 1'b0;
      if (!nrst) begin
         pend_q <= 1'b0;
         frame_trig <= 1'b0;
         hold_q <= 2'h0;
         cnt_q <= 8'h0;
      end else begin
         if (go)
            pend_q <= 1'b1;
         // rise only while waiting; rogue breaks this on purpose
         if ((pend_q && trig_wait && !frame_trig) || rogue) begin
            frame_trig <= 1'b1;
            pend_q <= 1'b0;
            hold_q <= 2'h3;
         end else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
         else
            frame_trig <= 1'b0;
         // flen sets a prompt or slow acquisition engine
         if (acq_start)
            cnt_q <= flen;
         else if (cnt_q != 8'h0)
            cnt_q <= cnt_q - 8'h1;
         if (cnt_q == 8'h1 && !acq_start)
            frame_done <= 1'b1;
      end
   end
endmodule

// file: ssa_stepper_tb_top.sv
`timescale 1ns/1ps
`include "ssa_stepper_regs.vh"
module ssa_stepper_tb_top;
   reg sys_clk = 1'b0;
   reg nrst = 1'b0;
   reg ce = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg go = 1'b0;
   reg rogue = 1'b0;
   reg [7:0] flen = 8'h14;
   wire frame_trig, frame_done, acq_start, trig_wait, seq_active, irq;
   wire [31:0] reg_rdata, acq_param;
   reg [31:0] v, par;
   reg [34:0] rows [0:6];
   int err_count = 0;
   int tests_run = 0;
   int i, n;
   always #2 sys_clk = ~sys_clk;
   ssa_stepper i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_trig(frame_trig),
      .frame_done(frame_done), .acq_start(acq_start), .acq_param(acq_param),
      .trig_wait(trig_wait), .seq_active(seq_active), .irq(irq));
   ssa_frame_src i_src (.sys_clk(sys_clk), .nrst(nrst), .go(go),
      .rogue(rogue), .flen(flen), .trig_wait(trig_wait),
      .acq_start(acq_start), .frame_trig(frame_trig),
      .frame_done(frame_done));
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, output [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task wait_idle;
      int k;
      k = 0;
      repeat (2) @(posedge sys_clk);
      #1;
      while (trig_wait !== 1'b1 && k < 200) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("trig_wait", {31'h0, trig_wait}, 32'h1);
   endtask
   // one frame; the write lands mid-frame, so it stays pending until done
   task frame(input [7:0] a, input [31:0] d, output [31:0] p);
      int k;
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      k = 0;
      #1;
      while (acq_start !== 1'b1 && k < 50) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("acq_start", {31'h0, acq_start}, 32'h1);
      p = acq_param;
      wr(a, d);
      wait_idle;
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      report_and_stop;
   end
   initial begin
      rows[0] = {3'h1, 32'h5E700000};
      rows[1] = {3'h1, 32'h5E700001};
      rows[2] = {3'h1, 32'h5E700002};
      rows[3] = {3'h1, 32'h5E700000};
      rows[4] = {3'h2, 32'h5E700001};
      rows[5] = {3'h0, 32'h5E700000};
      rows[6] = {3'h0, 32'h5E700000};
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`SSA_STATUS_OFS, v);
      check("status reset", v, 32'h1);
      rd(8'h20, v);
      check("unmapped", v, 32'h0);
      wr(`SSA_TOTAL_OFS, 32'h50);
      rd(`SSA_TOTAL_OFS, v);
      check("total clamp", v, 32'h40);
      wr(`SSA_TOTAL_OFS, 32'h3);
      for (i = 0; i < 3; i++) begin
         wr(`SSA_ACTIVE_OFS, 32'h5E700000 + i);
         wr(`SSA_INDEX_OFS, i);
         wr(`SSA_CMD_OFS, 32'h4);
      end
      wr(`SSA_ACTIVE_OFS, 32'hA5A50000);
      wr(`SSA_CTRL_OFS, 32'h1);
      wait_idle;
      check("seq_active", {31'h0, seq_active}, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      // each command written during a frame must show in the next frame's parameters
      for (i = 0; i < 7; i++) begin
         frame(`SSA_CMD_OFS, {29'h0, rows[i][34:32]}, par);
         check("acq_param", par, rows[i][31:0]);
      end
      rd(`SSA_IRQ_ST_OFS, v);
      wr(`SSA_IRQ_MASK_OFS, 32'hF);
      wr(`SSA_CMD_OFS, 32'h1);
      @(posedge sys_clk);
      rogue <= 1'b1;
      @(posedge sys_clk);
      rogue <= 1'b0;
      n = 0;
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         if (acq_start === 1'b1)
            n++;
      end
      check("start during load", n, 0);
      wait_idle;
      check("irq", {31'h0, irq}, 32'h1);
      rd(`SSA_IRQ_ST_OFS, v);
      check("ignored event", {31'h0, v[2]}, 32'h1);
      repeat (3) @(posedge sys_clk);
      #1;
      check("irq cleared", {31'h0, irq}, 32'h0);
      // both sources on a line code: step and rewind are both dropped
      wr(`SSA_CTRL_OFS, 32'h15);
      wr(`SSA_CMD_OFS, 32'h3);
      wait_idle;
      frame(`SSA_CTRL_OFS, 32'h0, par);
      check("blocked step", par, 32'h5E700001);
      check("seq stopped", {31'h0, seq_active}, 32'h0);
      rd(`SSA_ACTIVE_OFS, v);
      check("active restored", v, 32'hA5A50000);
      // clock enable low: a write in that window is lost
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(`SSA_IRQ_MASK_OFS, 32'h5);
      ce <= 1'b1;
      rd(`SSA_IRQ_MASK_OFS, v);
      check("mask frozen", v, 32'hF);
      // reset in mid-run brings the total back to one
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`SSA_TOTAL_OFS, v);
      check("total after reset", v, 32'h1);
      check("seq after reset", {31'h0, seq_active}, 32'h0);
      rd(`SSA_STATUS_OFS, v);
      check("status after reset", v, 32'h1);
      report_and_stop;
   end
endmodule
